// ### bench/lbs_dma_model.sv
// dma bus master model driving the sram second port
`timescale 1ns/1ps
`default_nettype none
module lbs_dma_model (
  // clock
  input wire logic mclk,
  // second port
  output logic dma_req,
  output logic dma_wr,
  output logic [1:0] dma_size,
  output logic [15:0] dma_addr,
  output logic [31:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic dma_err,
  input wire logic [31:0] dma_rdata
);
  int cyc;
  logic [31:0] rd;
  logic er;
  // idle port at time zero
  initial begin
    dma_req = 1'b0;
    dma_wr = 1'b0;
    dma_size = lbs_pkg::SZ_LONG;
    dma_addr = 16'h0000;
    dma_wdata = 32'h0000_0000;
  end
  // a lost arbitration gets no answer, so the request stays up and is re-presented
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    dma_req = 1'b1;
    dma_wr = w;
    dma_addr = a;
    dma_wdata = d;
    cyc = 0;
    do begin
      @(negedge mclk);
      cyc++;
    end while (dma_ack !== 1'b1 && dma_err !== 1'b1 && cyc < 9);
    rd = dma_rdata;
    er = dma_err;
    // released lines show garbage rather than the last value
    dma_req = 1'b0;
    dma_addr = ~a;
    dma_wdata = ~d;
  endtask : xfer
endmodule : lbs_dma_model
`default_nettype wire

// ### bench/lbs_top_tb.sv
// self-checking bench for the local bus sram
`timescale 1ns/1ps
`default_nettype none
module lbs_top_tb;
  logic mclk, reset, cpu_req, cpu_dbg, cpu_fetch, cpu_wr, cpu_hit, cpu_ack, cpu_stall, cpu_err;
  logic cpu_noncache, cpu_use_sram, cfg_core_wr, dbg_cfg_wr, dbg_cfg_rd, dma_req, dma_wr, dma_ack, dma_err;
  logic [1:0] cpu_size, dma_size;
  logic [2:0] cpu_space;
  logic [15:0] dma_addr;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, cfg_wdata, dbg_cfg_rdata, dma_wdata, dma_rdata, crd;
  int fails, comparisons, cyc;
  localparam logic [31:0] BASE = 32'h2000_0000;
  localparam logic [31:0] DAT = 32'h11aa_bbcc;
  lbs_top dut (.mclk, .reset, .cpu_req, .cpu_dbg, .cpu_fetch, .cpu_wr, .cpu_size, .cpu_space, .cpu_addr,
    .cpu_wdata, .cpu_hit, .cpu_ack, .cpu_stall, .cpu_err, .cpu_noncache, .cpu_use_sram, .cpu_rdata,
    .cfg_core_wr, .dbg_cfg_wr, .dbg_cfg_rd, .cfg_wdata, .dbg_cfg_rdata, .dma_req, .dma_wr, .dma_size,
    .dma_addr, .dma_wdata, .dma_ack, .dma_err, .dma_rdata);
  lbs_dma_model m (.mclk, .dma_req, .dma_wr, .dma_size, .dma_addr, .dma_wdata, .dma_ack, .dma_err,
    .dma_rdata);
  // 25 mhz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // comparison helpers
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic rst();
    @(negedge mclk);
    reset = 1'b1;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
  endtask : rst
  // config write by core or debug, and debug readback
  task automatic cfgw(input logic dbg, input logic [31:0] v);
    @(negedge mclk);
    cfg_core_wr = ~dbg;
    dbg_cfg_wr = dbg;
    cfg_wdata = v;
    @(negedge mclk);
    cfg_core_wr = 1'b0;
    dbg_cfg_wr = 1'b0;
    cfg_wdata = ~v;
  endtask : cfgw
  task automatic cfgr(input logic [31:0] e);
    @(negedge mclk);
    dbg_cfg_rd = 1'b1;
    @(negedge mclk);
    dbg_cfg_rd = 1'b0;
    chk("cfg", e, dbg_cfg_rdata);
  endtask : cfgr
  // one local bus access; a stall keeps the request up for a retry
  task automatic cpu(input logic w, input logic [1:0] sz, input logic [2:0] sp, input logic [31:0] a,
                     input logic [31:0] d, input logic dbg);
    @(negedge mclk);
    cpu_req = 1'b1;
    cpu_wr = w;
    cpu_size = sz;
    cpu_space = sp;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_dbg = dbg;
    cpu_fetch = (sp == lbs_pkg::AS_SUP_CODE);
    cyc = 0;
    do begin
      @(negedge mclk);
      cyc++;
    end while (cpu_stall === 1'b1 && cyc < 9);
    if (cpu_stall === 1'b1) begin
      fails++;
      test_done();
    end
    crd = cpu_rdata;
    cpu_req = 1'b0;
    cpu_wdata = ~d;
  endtask : cpu
  task automatic wr(input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
    cpu(1'b1, sz, lbs_pkg::AS_SUP_DATA, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [2:0] sp, input logic [31:0] a, input logic dbg);
    cpu(1'b0, lbs_pkg::SZ_LONG, sp, a, 32'h0000_0000, dbg);
  endtask : rd
  // dma transfer through the partner model; a port that never answers ends the run
  task automatic dx(input logic w, input logic [15:0] a, input logic [31:0] d);
    m.xfer(w, a, d);
    if (dma_ack !== 1'b1 && dma_err !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask : dx
  task automatic t_cfg();
    cfgw(1'b0, 32'h2000_f3c1);
    cfgr(32'h2000_f3c1 & lbs_pkg::CFG_WMASK);
    rst();
    cfgr(32'h2000_0300);
    rd(lbs_pkg::AS_SUP_DATA, BASE, 1'b0);
    chk("hit", 32'h0, cpu_hit);
    cfgw(1'b1, BASE | 32'h201);
    cfgr(BASE | 32'h201);
    $display("test cfg done");
  endtask : t_cfg
  task automatic t_data();
    wr(lbs_pkg::SZ_LONG, BASE + 4, 32'h1122_3344);
    chk("ack", 32'h1, cpu_ack);
    wr(lbs_pkg::SZ_BYTE, BASE + 5, 32'h0000_00aa);
    wr(lbs_pkg::SZ_WORD, BASE + 6, 32'h0000_bbcc);
    rd(lbs_pkg::AS_SUP_CODE, BASE + 4, 1'b0);
    chk("rdata", DAT, cpu_rdata);
    chk("cycles", 32'h1, cyc);
    chk("noncache", 32'h1, cpu_noncache);
    chk("use_sram", 32'h1, cpu_use_sram);
    rd(lbs_pkg::AS_SUP_DATA, 32'h3000_0004, 1'b0);
    chk("hit", 32'h0, cpu_hit);
    cfgw(1'b1, BASE | 32'h301);
    wr(lbs_pkg::SZ_LONG, BASE + 4, 32'hdead_beef);
    chk("err", 32'h1, cpu_err);
    rd(lbs_pkg::AS_SUP_DATA, BASE + 4, 1'b0);
    chk("rdata", DAT, cpu_rdata);
    chk("use_sram", 32'h0, cpu_use_sram);
    $display("test data done");
  endtask : t_data
  task automatic t_mask();
    for (int i = 0; i < 5; i++) begin
      cfgw(1'b1, BASE | 32'h201 | (32'h1 << (5 - i)));
      rd(3'(i), BASE + 4, 1'b0);
      chk("hit", 32'h0, cpu_hit);
      rd(3'((i + 1) % 5), BASE + 4, 1'b0);
      chk("hit", 32'h1, cpu_hit);
    end
    rd(lbs_pkg::AS_USR_DATA, BASE + 4, 1'b1);
    chk("rdata", DAT, cpu_rdata);
    $display("test mask done");
  endtask : t_mask
  task automatic t_dma();
    logic [15:0] a;
    logic w;
    cfgw(1'b1, BASE | 32'h001);
    dx(1'b0, 16'h0004, 32'h0);
    chk("dma_err", 32'h1, m.er);
    cfgw(1'b1, BASE | 32'h201);
    dx(1'b1, 16'h8010, 32'h5566_7788);
    rd(lbs_pkg::AS_SUP_DATA, BASE + 32'h8010, 1'b0);
    chk("rdata", 32'h5566_7788, cpu_rdata);
    fork
      rd(lbs_pkg::AS_SUP_DATA, BASE + 32'h8010, 1'b0);
      dx(1'b0, 16'h0004, 32'h0);
    join
    chk("cycles", 32'h2, cyc + m.cyc);
    for (int p = 0; p < 4; p++) begin
      cfgw(1'b1, BASE | 32'h201 | (32'(p) << 10));
      for (int b = 0; b < 2; b++) begin
        a = b ? 16'h8010 : 16'h0004;
        w = b ? !p[1] : !p[0];
        fork
          rd(lbs_pkg::AS_SUP_DATA, BASE | a, 1'b0);
          dx(1'b0, a, 32'h0);
        join
        chk("cpu_cycles", w ? 1 : 2, cyc);
        chk("dma_cycles", w ? 2 : 1, m.cyc);
        chk("cpu_rdata", b ? 32'h5566_7788 : DAT, crd);
        chk("dma_rdata", b ? 32'h5566_7788 : DAT, m.rd);
      end
    end
    $display("test dma done");
  endtask : t_dma
  // main sequence
  initial begin
    {cpu_req, cpu_dbg, cpu_fetch, cpu_wr, cfg_core_wr, dbg_cfg_wr, dbg_cfg_rd} = 7'h00;
    cpu_size = 2'h0;
    cpu_space = 3'h0;
    cpu_addr = 32'h0;
    cpu_wdata = 32'h0;
    cfg_wdata = 32'h0;
    reset = 1'b1;
    fails = 0;
    comparisons = 0;
    rst();
    t_cfg();
    t_data();
    t_mask();
    t_dma();
    test_done();
  end
endmodule : lbs_top_tb
`default_nettype wire

// ### hdl/lbs_bank.sv
// one 32-kbyte storage array with byte write enables and registered read data
`timescale 1ns/1ps
`default_nettype none
module lbs_bank #(
  parameter int AW = 13
) (
  // clock
  input wire logic mclk,
  // access
  input wire logic en,
  input wire logic [3:0] we,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:(1<<AW)-1];
  // contents are not cleared at reset, storage holds whatever it powered up with
  always_ff @(posedge mclk) begin // R20
    if (en) begin
      for (int i = 0; i < 4; i++) begin
        if (we[i]) begin
          mem[addr][i*8 +: 8] <= wdata[i*8 +: 8]; // R3
        end
      end
      rdata <= mem[addr];
    end
  end
endmodule : lbs_bank
`default_nettype wire

// ### hdl/lbs_cfg.sv
// configuration register: core writes only, debug reads and writes
`timescale 1ns/1ps
`default_nettype none
module lbs_cfg (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // core control-register write
  input wire logic core_wr,
  input wire logic [31:0] core_wdata,
  // debug access
  input wire logic dbg_wr,
  input wire logic [31:0] dbg_wdata,
  // contents
  output logic [31:0] cfg
);
  typedef struct packed {
    logic [31:0] cfg;
  } lbs_cfg_state_t;
  lbs_cfg_state_t st;
  lbs_cfg_state_t next_st;
  // debug write takes precedence when both land together
  always_comb begin
    next_st = st;
    if (core_wr) begin
      next_st.cfg = core_wdata & lbs_pkg::CFG_WMASK; // R10
    end
    if (dbg_wr) begin
      next_st.cfg = dbg_wdata & lbs_pkg::CFG_WMASK; // R9
    end
    // reserved bits forced low every cycle, so they read zero even before the first write
    next_st.cfg = next_st.cfg & lbs_pkg::CFG_WMASK; // R10
    if (reset) begin
      next_st.cfg[lbs_pkg::VALID_BIT] = 1'b0; // R11
    end
  end
  // no full reset here: only the valid bit is cleared, the rest survives
  always_ff @(posedge mclk) begin
    st <= next_st;
  end
  assign cfg = st.cfg;
  valid_clear_a: assert property (@(posedge mclk) reset |=> !cfg[lbs_pkg::VALID_BIT]) // R11
    else $error("valid bit not cleared by reset");
  // only a reset that meets a valid register is checked: at power-up the other bits are still unknown
  keep_other_a: assert property (@(posedge mclk) reset && cfg[lbs_pkg::VALID_BIT] && !dbg_wr && !core_wr |=> // R11
    cfg[31:1] == $past(cfg[31:1]))
    else $error("reset disturbed configuration");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (reset) // R10
    (cfg & ~lbs_pkg::CFG_WMASK) == 32'h0000_0000)
    else $error("reserved configuration bit set");
endmodule : lbs_cfg
`default_nettype wire

// ### hdl/lbs_pkg.sv
// package: configuration register layout and port encodings for the local bus sram
package lbs_pkg;
  localparam int BASE_HI = 31;
  localparam int BASE_LO = 16;
  localparam int UPPER_PRI_BIT = 11;
  localparam int LOWER_PRI_BIT = 10;
  localparam int SPV_BIT = 9;
  localparam int WP_BIT = 8;
  localparam int MASK_CI_BIT = 5;
  localparam int MASK_SC_BIT = 4;
  localparam int MASK_SD_BIT = 3;
  localparam int MASK_UC_BIT = 2;
  localparam int MASK_UD_BIT = 1;
  localparam int VALID_BIT = 0;
  // writable bits: base, priorities, port enable, protect, space masks, valid
  localparam logic [31:0] CFG_WMASK = 32'hffff_0f3f;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int BANK_AW = 13;
  // transfer size encoding
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // address space encoding of the core bus
  localparam logic [2:0] AS_CPU = 3'h0;
  localparam logic [2:0] AS_SUP_CODE = 3'h1;
  localparam logic [2:0] AS_SUP_DATA = 3'h2;
  localparam logic [2:0] AS_USR_CODE = 3'h3;
  localparam logic [2:0] AS_USR_DATA = 3'h4;
  typedef enum logic [1:0] {
    LBS_IDLE = 2'b00,
    LBS_HOLD = 2'b01
  } lbs_dma_state_t;
endpackage : lbs_pkg

// ### hdl/lbs_top.sv
// local bus sram: two 32-kbyte banks, core/debug port, dma port, config register
// Function
// R1 - core local bus accesses complete in one cycle, no wait states
// R2 - claim when address bits 31..16 equal programmed base field
// R3 - byte, word and longword reads and writes touching only addressed bytes
// R4 - on a fetch hit the sram data replaces the cache result
// R5 - sram hits are flagged non-cacheable
// R6 - two 32-kbyte arrays let core and dma work different banks together
// R7 - debug module memory commands are served like core accesses
// R8 - core may write config register but cannot read it back
// R9 - debug module can read and write the config register
// R10 - undefined config bits ignore writes and read zero
// R11 - reset clears only the valid bit
// R12 - bit 11 set gives dma priority in upper bank
// R13 - bit 10 set gives dma priority in lower bank
// R14 - priority field 00,01,10,11 decodes per bank as table
// R15 - dma accesses refused while second port enable bit is clear
// R16 - write protect blocks core writes and raises an access error
// R17 - bits 5..1 mask address spaces; masked references are not claimed
// R18 - valid bit clear means no access is claimed
// R19 - loser of a same-bank conflict stalls and is served later intact
// R20 - storage contents are undefined after reset, no clearing
`timescale 1ns/1ps
`default_nettype none
module lbs_top #(
  parameter int BANK_AW = lbs_pkg::BANK_AW
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // core local bus (core or debug master)
  input wire logic cpu_req,
  input wire logic cpu_dbg,
  input wire logic cpu_fetch,
  input wire logic cpu_wr,
  input wire logic [1:0] cpu_size,
  input wire logic [2:0] cpu_space,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_hit,
  output logic cpu_ack,
  output logic cpu_stall,
  output logic cpu_err,
  output logic cpu_noncache,
  output logic cpu_use_sram,
  output logic [31:0] cpu_rdata,
  // configuration register access
  input wire logic cfg_core_wr,
  input wire logic dbg_cfg_wr,
  input wire logic dbg_cfg_rd,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] dbg_cfg_rdata,
  // dma port, offset within the 64-kbyte region
  input wire logic dma_req,
  input wire logic dma_wr,
  input wire logic [1:0] dma_size,
  input wire logic [15:0] dma_addr,
  input wire logic [31:0] dma_wdata,
  output logic dma_ack,
  output logic dma_err,
  output logic [31:0] dma_rdata
);
  typedef struct packed {
    logic cpu_hit;
    logic cpu_ack;
    logic cpu_stall;
    logic cpu_err;
    logic cpu_rd;
    logic cpu_fetch_hit;
    logic cpu_bank;
    logic dma_ack;
    logic dma_err;
    logic dma_rd;
    logic dma_bank;
    logic [31:0] dbg_cfg_rdata;
  } lbs_state_t;

  lbs_state_t st;
  lbs_state_t next_st;
  logic [31:0] cfg;
  logic [31:0] bank_rdata [2];
  logic [3:0] cpu_be;
  logic [3:0] dma_be;
  logic cpu_claim;
  logic cpu_wp_fault;
  logic cpu_go;
  logic dma_ok;
  logic dma_go;
  logic cpu_bank;
  logic dma_bank;
  logic dma_wins;
  logic bank_en [2];
  logic [3:0] bank_we [2];
  logic [BANK_AW-1:0] bank_addr [2];
  logic [31:0] bank_wdata [2];

  // byte lanes from size and low address, big-endian: byte 0 in lane 3
  function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hf;
    case (size)
      lbs_pkg::SZ_BYTE: m = 4'h8 >> a;
      lbs_pkg::SZ_WORD: m = a[1] ? 4'h3 : 4'hc;
      default: m = 4'hf;
    endcase
    return m;
  endfunction : lane_mask

  // place write data on its lanes
  function automatic logic [31:0] lane_data(input logic [1:0] size, input logic [31:0] d);
    logic [31:0] r;
    r = d;
    case (size)
      lbs_pkg::SZ_BYTE: r = {4{d[7:0]}};
      lbs_pkg::SZ_WORD: r = {2{d[15:0]}};
      default: r = d;
    endcase
    return r;
  endfunction : lane_data

  // address space masked by the configuration
  function automatic logic space_masked(input logic [2:0] sp, input logic [31:0] c);
    logic m;
    m = 1'b0;
    case (sp)
      lbs_pkg::AS_CPU: m = c[lbs_pkg::MASK_CI_BIT];
      lbs_pkg::AS_SUP_CODE: m = c[lbs_pkg::MASK_SC_BIT];
      lbs_pkg::AS_SUP_DATA: m = c[lbs_pkg::MASK_SD_BIT];
      lbs_pkg::AS_USR_CODE: m = c[lbs_pkg::MASK_UC_BIT];
      lbs_pkg::AS_USR_DATA: m = c[lbs_pkg::MASK_UD_BIT];
      default: m = 1'b0;
    endcase
    return m;
  endfunction : space_masked

  // configuration register
  lbs_cfg u_cfg (
    .mclk(mclk),
    .reset(reset),
    .core_wr(cfg_core_wr),
    .core_wdata(cfg_wdata),
    .dbg_wr(dbg_cfg_wr),
    .dbg_wdata(cfg_wdata),
    .cfg(cfg)
  );

  // address decode; debug commands use the same path as the core
  always_comb begin
    cpu_claim = cpu_req && cfg[lbs_pkg::VALID_BIT] // R18
      && cpu_addr[31:16] == cfg[lbs_pkg::BASE_HI:lbs_pkg::BASE_LO] // R2
      && (cpu_dbg || !space_masked(cpu_space, cfg)); // R17 R7
    cpu_wp_fault = cpu_claim && cpu_wr && cfg[lbs_pkg::WP_BIT]; // R16
    cpu_bank = cpu_addr[15];
    dma_bank = dma_addr[15];
    dma_ok = dma_req && cfg[lbs_pkg::VALID_BIT] && cfg[lbs_pkg::SPV_BIT]; // R15
    cpu_be = lane_mask(cpu_size, cpu_addr[1:0]);
    dma_be = lane_mask(dma_size, dma_addr[1:0]);
  end

  // bank arbitration: priority bit per bank picks the winner of a clash
  always_comb begin
    dma_wins = dma_bank ? cfg[lbs_pkg::UPPER_PRI_BIT] // R12 R14
                        : cfg[lbs_pkg::LOWER_PRI_BIT]; // R13 R14
    cpu_go = cpu_claim && !cpu_wp_fault;
    dma_go = dma_ok;
    if (cpu_go && dma_go && cpu_bank == dma_bank) begin // R19
      if (dma_wins) begin
        cpu_go = 1'b0;
      end else begin
        dma_go = 1'b0;
      end
    end
  end

  // steer each requester onto its bank; different banks run together
  always_comb begin
    for (int b = 0; b < 2; b++) begin // R6
      bank_en[b] = 1'b0;
      bank_we[b] = 4'h0;
      bank_addr[b] = '0;
      bank_wdata[b] = 32'h0000_0000;
      if (dma_go && dma_bank == b[0]) begin
        bank_en[b] = 1'b1;
        bank_we[b] = dma_wr ? dma_be : 4'h0;
        bank_addr[b] = dma_addr[BANK_AW+1:2];
        bank_wdata[b] = lane_data(dma_size, dma_wdata);
      end else if (cpu_go && cpu_bank == b[0]) begin
        bank_en[b] = 1'b1;
        bank_we[b] = cpu_wr ? cpu_be : 4'h0; // R3
        bank_addr[b] = cpu_addr[BANK_AW+1:2];
        bank_wdata[b] = lane_data(cpu_size, cpu_wdata);
      end
    end
  end

  // the two storage arrays
  lbs_bank #(.AW(BANK_AW)) u_lo (
    .mclk(mclk),
    .en(bank_en[0]),
    .we(bank_we[0]),
    .addr(bank_addr[0]),
    .wdata(bank_wdata[0]),
    .rdata(bank_rdata[0])
  );
  lbs_bank #(.AW(BANK_AW)) u_hi (
    .mclk(mclk),
    .en(bank_en[1]),
    .we(bank_we[1]),
    .addr(bank_addr[1]),
    .wdata(bank_wdata[1]),
    .rdata(bank_rdata[1])
  );

  // response flags; answer one cycle after the request edge
  always_comb begin
    next_st = st;
    next_st.cpu_hit = cpu_claim;
    next_st.cpu_ack = cpu_go; // R1
    next_st.cpu_stall = cpu_claim && !cpu_go && !cpu_wp_fault; // R19
    next_st.cpu_err = cpu_wp_fault; // R16
    next_st.cpu_rd = cpu_go && !cpu_wr;
    next_st.cpu_fetch_hit = cpu_claim && cpu_fetch; // R4
    next_st.cpu_bank = cpu_bank;
    next_st.dma_ack = dma_go;
    next_st.dma_err = dma_req && !dma_ok; // R15
    next_st.dma_rd = dma_go && !dma_wr;
    next_st.dma_bank = dma_bank;
    // core has no read path for the config register, only debug does
    next_st.dbg_cfg_rdata = dbg_cfg_rd ? cfg : 32'h0000_0000; // R8 R9 R10
    if (reset) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // outputs; read data comes straight from the bank's output register
  assign cpu_hit = st.cpu_hit;
  assign cpu_ack = st.cpu_ack;
  assign cpu_stall = st.cpu_stall;
  assign cpu_err = st.cpu_err;
  assign cpu_noncache = st.cpu_hit; // R5
  assign cpu_use_sram = st.cpu_fetch_hit; // R4 fetch hit: the cache result is dropped
  assign cpu_rdata = st.cpu_rd ? bank_rdata[st.cpu_bank] : 32'h0000_0000;
  assign dma_ack = st.dma_ack;
  assign dma_err = st.dma_err;
  assign dma_rdata = st.dma_rd ? bank_rdata[st.dma_bank] : 32'h0000_0000;
  assign dbg_cfg_rdata = st.dbg_cfg_rdata;

  single_cycle_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_claim && !cpu_wr && !(dma_ok && dma_bank == cpu_bank) |=> cpu_ack) // R1
    else $error("uncontested core read not answered next cycle");
  base_match_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_hit |-> $past(cpu_addr[31:16]) == $past(cfg[31:16])) // R2
    else $error("claim outside base region");
  disabled_idle_a: assert property (@(posedge mclk) disable iff (reset)
    !cfg[lbs_pkg::VALID_BIT] |=> !cpu_hit && !dma_ack) // R18
    else $error("claim while disabled");
  wp_error_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_claim && cpu_wr && cfg[lbs_pkg::WP_BIT] |=> cpu_err && !cpu_ack) // R16
    else $error("protected write not refused");
  dma_refuse_a: assert property (@(posedge mclk) disable iff (reset)
    dma_req && !cfg[lbs_pkg::SPV_BIT] |=> dma_err && !dma_ack) // R15
    else $error("dma served with port disabled");
  upper_pri_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_claim && !cpu_wp_fault && dma_ok && cpu_bank && dma_bank |=>
    (dma_ack != cpu_ack) && (dma_ack == $past(cfg[lbs_pkg::UPPER_PRI_BIT]))) // R12 R14
    else $error("upper bank priority wrong");
  lower_pri_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_claim && !cpu_wp_fault && dma_ok && !cpu_bank && !dma_bank |=>
    (dma_ack != cpu_ack) && (dma_ack == $past(cfg[lbs_pkg::LOWER_PRI_BIT]))) // R13 R14
    else $error("lower bank priority wrong");
  diff_bank_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_claim && !cpu_wp_fault && dma_ok && cpu_bank != dma_bank |=> cpu_ack && dma_ack) // R6
    else $error("parallel bank access blocked");
  mask_space_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_req && !cpu_dbg && space_masked(cpu_space, cfg) |=> !cpu_hit) // R17
    else $error("masked space claimed");
  stall_loser_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_stall |-> !cpu_ack ##0 $past(dma_ok)) // R19
    else $error("core stalled without contention");
  noncache_a: assert property (@(posedge mclk) disable iff (reset)
    cpu_claim |=> cpu_noncache && (cpu_use_sram == $past(cpu_fetch))) // R5 R4
    else $error("hit not flagged non-cacheable");
  conflict_stall_a: assert property (@(posedge mclk) disable iff (reset) // R19
    cpu_claim && !cpu_wp_fault && dma_ok && cpu_bank == dma_bank && dma_wins |=> cpu_stall && !cpu_ack)
    else $error("core not stalled on lost conflict");
  wp_no_write_a: assert property (@(posedge mclk) disable iff (reset) // R16
    cpu_wp_fault && !(dma_go && dma_bank == cpu_bank) |-> bank_we[cpu_bank] == 4'h0)
    else $error("protected write reached the array");
  byte_lane_a: assert property (@(posedge mclk) disable iff (reset) // R3
    cpu_go && cpu_wr && cpu_size == lbs_pkg::SZ_BYTE |-> $onehot(bank_we[cpu_bank]))
    else $error("byte write touched more than one lane");
  // reset quiets every answer so a stale strobe cannot leak out of it
  reset_quiet_a: assert property (@(posedge mclk) // R18
    reset |=> !cpu_hit && !cpu_ack && !dma_ack)
    else $error("answer raised during reset");
  dbg_read_a: assert property (@(posedge mclk) disable iff (reset) // R9
    dbg_cfg_rd |=> dbg_cfg_rdata == $past(cfg))
    else $error("debug readback differs from register");
endmodule : lbs_top
`default_nettype wire
